// ==== rtl/scp_pkg.sv ====
package scp_pkg;
   // Serial frame geometry
   localparam int INSTR_BITS = 16;
   localparam int BYTE_BITS = 8;
   localparam int ADDR_W = 10;
   localparam logic [1:0] LEN_STREAM = 2'h3;
   localparam logic [9:0] ADDR_TOP = 10'h232;
   localparam logic [9:0] ADDR_BOTTOM = 10'h000;
   localparam logic [9:0] ADDR_UPDATE = 10'h232;
   localparam int UPDATE_BIT = 0;

   // Device register file, table order
   localparam int NREG = 10;
   localparam int IDX_PORT = 0;
   localparam int IDX_RBK = 1;
   localparam int IDX_PFD = 2;
   localparam int IDX_RDIV_LO = 3;
   localparam int IDX_RDIV_HI = 4;
   localparam int IDX_SWALLOW = 5;
   localparam int IDX_FB_LO = 6;
   localparam int IDX_FB_HI = 7;
   localparam int IDX_CTL1 = 8;
   localparam int IDX_CTL2 = 9;
   localparam logic [9:0] REG_ADDR [NREG] = '{10'h000, 10'h004, 10'h010, 10'h011, 10'h012,
                                              10'h013, 10'h014, 10'h015, 10'h016, 10'h017};
   localparam logic [7:0] REG_RST [NREG] = '{8'h18, 8'h00, 8'h7d, 8'h01, 8'h00,
                                             8'h00, 8'h03, 8'h00, 8'h06, 8'h00};

   // Field positions
   localparam int PORT_SDO_BIT = 7;
   localparam int PORT_LSB_BIT = 6;
   localparam int RBK_ACTIVE_BIT = 0;
   localparam int CTL1_RST_R_BIT = 6;
   localparam int CTL1_RST_AB_BIT = 5;
   localparam int CTL1_RST_ALL_BIT = 4;
   localparam int CTL1_BBYP_BIT = 3;

   // Controller registers on the system bus
   localparam logic [7:0] H_INSTR = 8'h00;
   localparam logic [7:0] H_TXDATA = 8'h04;
   localparam logic [7:0] H_CTRL = 8'h08;
   localparam logic [7:0] H_STATUS = 8'h0c;
   localparam logic [7:0] H_RXDATA = 8'h10;
   localparam int CTRL_LSB_BIT = 8;
   localparam int CTRL_SDO_BIT = 9;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int HALF_PERIOD_CYC = 4;
endpackage

// ==== rtl/scp_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface scp_link_if;
   logic cs_n;
   logic sclk;
   logic host_sdio;
   logic host_sdio_oe;
   logic dev_sdio;
   logic dev_sdio_oe;
   logic dev_sdo;
   logic sdio;

   // Resolved data wire, pulled high when nobody drives
   assign sdio = host_sdio_oe ? host_sdio : (dev_sdio_oe ? dev_sdio : 1'b1);

   modport host (output cs_n, output sclk, output host_sdio, output host_sdio_oe,
                 input sdio, input dev_sdo);
   modport dev (input cs_n, input sclk, input sdio,
                output dev_sdio, output dev_sdio_oe, output dev_sdo);
endinterface
`default_nettype wire

// ==== rtl/scp_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
module scp_dev (
   // Serial link
   scp_link_if.dev link,
   // Power-on reset
   input wire logic arst_n_i,
   // Active PLL settings
   output logic [7:0] pfd_pump_o,
   output logic [13:0] ref_div_o,
   output logic [5:0] swallow_o,
   output logic [12:0] feedback_o,
   output logic rst_ref_cnt_o,
   output logic rst_ab_cnt_o,
   output logic rst_all_cnt_o,
   output logic fb_bypass_o,
   output logic [2:0] prescaler_o,
   output logic [7:0] pll_ctl2_o,
   // Port mode as seen by the link
   output logic lsb_first_o,
   output logic sdo_active_o
);
   logic frm_rst_n;
   logic [4:0] cnt_ff;
   logic [15:0] sh_ff;
   logic [15:0] nxt_sh;
   logic rw_ff;
   logic [1:0] len_ff;
   logic [1:0] left_ff;
   logic [9:0] addr_ff;
   logic wrap_ff;
   logic stop_ff;
   logic lsb;
   logic instr_done;
   logic byte_done;
   logic last_byte;
   logic [7:0] byte_in;
   logic wr_en;
   logic update;
   logic [7:0] buf_ff [scp_pkg::NREG];
   logic [7:0] act_ff [scp_pkg::NREG];
   logic [7:0] rd_byte;
   logic [2:0] rd_idx;
   logic out_ff;
   logic drive_ff;

   // Chip-select high clears the frame logic at once; the link clock
   // stops between frames, so no edge may be relied on after the end
   // cycle end
   assign frm_rst_n = arst_n_i & ~link.cs_n;

   // Port mode acts immediately, no update needed
   assign lsb = buf_ff[scp_pkg::IDX_PORT][scp_pkg::PORT_LSB_BIT];

   // Shift direction follows the bit order
   // LSB-first shift
   always_comb begin
      if (lsb) begin
         nxt_sh = {link.sdio, sh_ff[15:1]};
         byte_in = nxt_sh[15:8];
      end else begin
         nxt_sh = {sh_ff[14:0], link.sdio};
         byte_in = nxt_sh[7:0];
      end
   end

   assign instr_done = (cnt_ff == 5'(scp_pkg::INSTR_BITS - 1));
   assign byte_done = (cnt_ff == 5'(scp_pkg::INSTR_BITS + scp_pkg::BYTE_BITS - 1));

   // End of transfer: counted bytes, or the stream hits its stop address
   // length codes
   always_comb begin
      if (len_ff != scp_pkg::LEN_STREAM) begin
         last_byte = (left_ff == 2'h0);
      end else if (lsb) begin
         last_byte = (addr_ff == scp_pkg::ADDR_TOP);
      end else begin
         last_byte = wrap_ff && (addr_ff == scp_pkg::ADDR_TOP);
      end
   end

   // Bit counter: 16 instruction bits, then 8 per byte, repeating
   // rising edge sample
   always_ff @(posedge link.sclk or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         cnt_ff <= 5'h00;
         sh_ff <= 16'h0000;
      end else begin
         sh_ff <= nxt_sh;
         if (byte_done) begin
            cnt_ff <= 5'(scp_pkg::INSTR_BITS);
         end else begin
            cnt_ff <= cnt_ff + 5'h01;
         end
      end
   end

   // Instruction decode and address generator
   always_ff @(posedge link.sclk or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         rw_ff <= 1'b0;
         len_ff <= 2'h0;
         left_ff <= 2'h0;
         addr_ff <= 10'h000;
         wrap_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else if (instr_done) begin
         rw_ff <= nxt_sh[15];
         len_ff <= nxt_sh[14:13];
         left_ff <= nxt_sh[14:13];
         addr_ff <= nxt_sh[scp_pkg::ADDR_W-1:0];
         wrap_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else if (byte_done && !stop_ff) begin
         left_ff <= left_ff - 2'h1;
         if (last_byte) begin
            stop_ff <= 1'b1;
         end else if (lsb) begin
            addr_ff <= addr_ff + 10'h001;
         end else if (addr_ff == scp_pkg::ADDR_BOTTOM) begin
            addr_ff <= scp_pkg::ADDR_TOP;
            wrap_ff <= 1'b1;
         end else begin
            addr_ff <= addr_ff - 10'h001;
         end
      end
   end

   // Writes land in the buffer; the update bit copies all at once
   // every mapped address visited
   assign wr_en = byte_done && !stop_ff && !rw_ff;
   assign update = wr_en && (addr_ff == scp_pkg::ADDR_UPDATE) && byte_in[scp_pkg::UPDATE_BIT];

   // Buffer and active copy per register; unmapped addresses drop data
   for (genvar i = 0; i < scp_pkg::NREG; i++) begin : g_reg
      always_ff @(posedge link.sclk or negedge arst_n_i) begin
         if (!arst_n_i) begin
            buf_ff[i] <= scp_pkg::REG_RST[i];
         end else if (wr_en && addr_ff == scp_pkg::REG_ADDR[i]) begin
            buf_ff[i] <= byte_in;
         end
      end

      always_ff @(posedge link.sclk or negedge arst_n_i) begin
         if (!arst_n_i) begin
            act_ff[i] <= scp_pkg::REG_RST[i];
         end else if (update) begin
            act_ff[i] <= buf_ff[i];
         end
      end
   end

   // Readback source: buffer or active copy, zero for unmapped
   // readback source
   always_comb begin
      rd_byte = 8'h00;
      for (int i = 0; i < scp_pkg::NREG; i++) begin
         if (addr_ff == scp_pkg::REG_ADDR[i]) begin
            if (buf_ff[scp_pkg::IDX_RBK][scp_pkg::RBK_ACTIVE_BIT]) begin
               rd_byte = act_ff[i];
            end else begin
               rd_byte = buf_ff[i];
            end
         end
      end
   end

   // Bit position within the byte follows the bit order
   // LSB-first readback
   assign rd_idx = lsb ? cnt_ff[2:0] : 3'h7 - cnt_ff[2:0];

   // Read data changes on the falling edge, valid for the next rise
   always_ff @(negedge link.sclk or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         out_ff <= 1'b0;
         drive_ff <= 1'b0;
      end else begin
         out_ff <= rd_byte[rd_idx];
         drive_ff <= rw_ff && (cnt_ff >= 5'(scp_pkg::INSTR_BITS)) && !stop_ff;
      end
   end

   // Link outputs; three-wire mode drives the shared data line
   always_comb begin
      link.dev_sdio = out_ff;
      link.dev_sdio_oe = drive_ff && !buf_ff[scp_pkg::IDX_PORT][scp_pkg::PORT_SDO_BIT];
      link.dev_sdo = out_ff;
   end

   // Active settings toward the PLL
   // split divider
   assign ref_div_o = {act_ff[scp_pkg::IDX_RDIV_HI][5:0], act_ff[scp_pkg::IDX_RDIV_LO]};
   assign pfd_pump_o = act_ff[scp_pkg::IDX_PFD];
   assign swallow_o = act_ff[scp_pkg::IDX_SWALLOW][5:0];
   assign feedback_o = {act_ff[scp_pkg::IDX_FB_HI][4:0], act_ff[scp_pkg::IDX_FB_LO]};
   assign rst_ref_cnt_o = act_ff[scp_pkg::IDX_CTL1][scp_pkg::CTL1_RST_R_BIT];
   assign rst_ab_cnt_o = act_ff[scp_pkg::IDX_CTL1][scp_pkg::CTL1_RST_AB_BIT];
   assign rst_all_cnt_o = act_ff[scp_pkg::IDX_CTL1][scp_pkg::CTL1_RST_ALL_BIT];
   assign fb_bypass_o = act_ff[scp_pkg::IDX_CTL1][scp_pkg::CTL1_BBYP_BIT];
   assign prescaler_o = act_ff[scp_pkg::IDX_CTL1][2:0];
   assign pll_ctl2_o = act_ff[scp_pkg::IDX_CTL2];
   assign lsb_first_o = lsb;
   assign sdo_active_o = buf_ff[scp_pkg::IDX_PORT][scp_pkg::PORT_SDO_BIT];
endmodule
`default_nettype wire

// ==== rtl/scp_host.sv ====
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module scp_host #(
   parameter int HALF = scp_pkg::HALF_PERIOD_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic [31:0] hrdata_o,
   output logic hresp_o,
   // Serial link
   scp_link_if.host link
);
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_HOLD} scp_hst_t;
   scp_hst_t st_ff;
   logic [15:0] instr_ff;
   logic [31:0] tx_ff;
   logic [31:0] rx_ff;
   logic [2:0] nb_ff;
   logic lsb_ff;
   logic use_sdo_ff;
   logic done_ff;
   logic ap_wr_ff;
   logic [7:0] ap_addr_ff;
   logic [31:0] rdata_ff;
   logic [7:0] tmr_ff;
   logic tick;
   logic [5:0] bit_ff;
   logic [5:0] last_bit;
   logic [5:0] nxt_bit;
   logic start;
   logic cs_n_ff;
   logic sclk_ff;
   logic sd_ff;
   logic oe_ff;
   logic sdio_s1_ff;
   logic sdio_s2_ff;
   logic sdo_s1_ff;
   logic sdo_s2_ff;
   logic rx_bit;
   logic [4:0] rx_pos;

   // Map a frame bit number to its place in instruction or data
   function automatic logic frame_bit(input logic [5:0] k, input logic lsb,
                                      input logic [15:0] ins, input logic [31:0] dat);
      logic [4:0] pos;
      pos = {k[4:3] - 2'h2, lsb ? k[2:0] : 3'h7 - k[2:0]};
      if (k < 6'(scp_pkg::INSTR_BITS)) begin
         frame_bit = lsb ? ins[k[3:0]] : ins[4'hf - k[3:0]];
      end else begin
         frame_bit = dat[pos];
      end
   endfunction

   // Address phase capture; the slave never inserts wait states
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ap_wr_ff <= 1'b0;
         ap_addr_ff <= 8'h00;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ap_wr_ff <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
         ap_addr_ff <= haddr_i[7:0];
         rdata_ff <= 32'h0000_0000;
         case (haddr_i[7:0])
            scp_pkg::H_INSTR: rdata_ff <= {16'h0000, instr_ff};
            scp_pkg::H_TXDATA: rdata_ff <= tx_ff;
            scp_pkg::H_CTRL: rdata_ff <= {22'h0, use_sdo_ff, lsb_ff, 5'h00, nb_ff};
            scp_pkg::H_STATUS: rdata_ff <= {30'h0, done_ff, st_ff != ST_IDLE};
            scp_pkg::H_RXDATA: rdata_ff <= rx_ff;
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end
   end
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = rdata_ff;

   // A write to the control word starts a frame when idle
   assign start = ap_wr_ff && ap_addr_ff == scp_pkg::H_CTRL && st_ff == ST_IDLE;

   // Software registers
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         instr_ff <= 16'h0000;
         tx_ff <= 32'h0000_0000;
         nb_ff <= 3'h0;
         lsb_ff <= 1'b0;
         use_sdo_ff <= 1'b0;
      end else if (ap_wr_ff && st_ff == ST_IDLE) begin
         if (ap_addr_ff == scp_pkg::H_INSTR) begin
            instr_ff <= {hwdata_i[15:13], 3'h0, hwdata_i[9:0]};
         end
         if (ap_addr_ff == scp_pkg::H_TXDATA) begin
            tx_ff <= hwdata_i;
         end
         if (ap_addr_ff == scp_pkg::H_CTRL) begin
            nb_ff <= hwdata_i[2:0];
            lsb_ff <= hwdata_i[scp_pkg::CTRL_LSB_BIT];
            use_sdo_ff <= hwdata_i[scp_pkg::CTRL_SDO_BIT];
         end
      end
   end

   // Two-flop synchronisers for the returning data
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sdio_s1_ff <= 1'b1;
         sdio_s2_ff <= 1'b1;
         sdo_s1_ff <= 1'b0;
         sdo_s2_ff <= 1'b0;
      end else begin
         sdio_s1_ff <= link.sdio;
         sdio_s2_ff <= sdio_s1_ff;
         sdo_s1_ff <= link.dev_sdo;
         sdo_s2_ff <= sdo_s1_ff;
      end
   end

   // Half-period timer of the clock divider
   assign tick = (tmr_ff == 8'(HALF - 1));
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tmr_ff <= 8'h00;
      end else if (tick || st_ff == ST_IDLE) begin
         tmr_ff <= 8'h00;
      end else begin
         tmr_ff <= tmr_ff + 8'h01;
      end
   end

   assign last_bit = 6'(scp_pkg::INSTR_BITS - 1) + {nb_ff, 3'h0};
   assign nxt_bit = bit_ff + 6'h01;
   assign rx_bit = use_sdo_ff ? sdo_s2_ff : sdio_s2_ff;
   assign rx_pos = {bit_ff[4:3] - 2'h2, lsb_ff ? bit_ff[2:0] : 3'h7 - bit_ff[2:0]};

   // Frame sequencer; clock low first, data changes while low
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= ST_IDLE;
         cs_n_ff <= 1'b1;
         sclk_ff <= 1'b0;
         sd_ff <= 1'b0;
         oe_ff <= 1'b0;
         bit_ff <= 6'h00;
         done_ff <= 1'b0;
         rx_ff <= 32'h0000_0000;
      end else begin
         case (st_ff)
            ST_IDLE: begin
               if (start) begin
                  cs_n_ff <= 1'b0;
                  done_ff <= 1'b0;
                  bit_ff <= 6'h00;
                  st_ff <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (tick) begin
                  sd_ff <= frame_bit(6'h00, lsb_ff, instr_ff, tx_ff);
                  oe_ff <= 1'b1;
                  st_ff <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (tick) begin
                  if (instr_ff[15] && bit_ff >= 6'(scp_pkg::INSTR_BITS)) begin
                     rx_ff[rx_pos] <= rx_bit;
                  end
                  sclk_ff <= 1'b1;
                  st_ff <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (tick) begin
                  sclk_ff <= 1'b0;
                  if (bit_ff == last_bit) begin
                     oe_ff <= 1'b0;
                     st_ff <= ST_HOLD;
                  end else begin
                     bit_ff <= nxt_bit;
                     sd_ff <= frame_bit(nxt_bit, lsb_ff, instr_ff, tx_ff);
                     oe_ff <= !(instr_ff[15] && nxt_bit >= 6'(scp_pkg::INSTR_BITS));
                     st_ff <= ST_LOW;
                  end
               end
            end
            ST_HOLD: begin
               if (tick) begin
                  cs_n_ff <= 1'b1;
                  done_ff <= 1'b1;
                  st_ff <= ST_IDLE;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // Link pins
   always_comb begin
      link.cs_n = cs_n_ff;
      link.sclk = sclk_ff;
      link.host_sdio = sd_ff;
      link.host_sdio_oe = oe_ff;
   end
endmodule
`default_nettype wire

// ==== test/scp_link_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module scp_link_sva (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // Link signals
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic host_sdio,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio_oe,
   input wire logic dev_sdo
);
   logic sclk_q_ff;
   logic [11:0] rises_ff;

   // Serial rises within the current frame, cleared while deselected
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sclk_q_ff <= 1'b0;
         rises_ff <= 12'h000;
      end else begin
         sclk_q_ff <= sclk;
         rises_ff <= cs_n ? 12'h000 : rises_ff + {11'h000, sclk & ~sclk_q_ff};
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   // Clock steps: low before the first rise, a full high phase
   sequence s_low_setup;
      !sclk [*4];
   endsequence
   sequence s_high_phase;
      sclk [*4] ##1 !sclk;
   endsequence

   a_sclk_idle_low: assert property (cs_n |-> !sclk)
      else $error("serial clock active while deselected");
   a_cs_setup: assert property ($fell(cs_n) |-> s_low_setup)
      else $error("serial clock rose too soon after select");
   a_cs_hold: assert property ($rose(cs_n) |-> $past(sclk, 1) == 1'b0 && $past(sclk, 3) == 1'b0)
      else $error("deselect too close to last clock");
   a_sclk_high_phase: assert property ($rose(sclk) |-> s_high_phase)
      else $error("serial clock high phase wrong length");
   a_host_data_stable: assert property ($rose(sclk) && host_sdio_oe |-> $stable(host_sdio) ##1 $stable(host_sdio))
      else $error("host data moved around rising edge");
   a_single_driver: assert property (!(host_sdio_oe && dev_sdio_oe))
      else $error("both ends drive the data line");
   a_idle_released: assert property (cs_n |-> !host_sdio_oe && !dev_sdio_oe)
      else $error("data line driven while deselected");
   a_dev_after_instr: assert property (dev_sdio_oe |-> rises_ff >= 12'd16)
      else $error("device drove before instruction end");
   a_frame_whole_bytes: assert property ($rose(cs_n) |-> rises_ff >= 12'd16 && rises_ff[2:0] == 3'h0)
      else $error("frame ended off a byte boundary");
   a_dev_out_on_fall: assert property ($changed(dev_sdo) |-> !sclk)
      else $error("device output changed with clock high");
endmodule
`default_nettype wire

// ==== test/test_serial_control_port_regmap.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_control_port_regmap;
   logic sys_clk_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
   // Starts high so reset begins with a real falling edge; the device
   // registers have no running clock during reset and see only that edge
   logic arst_n_i = 1'b1;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rx, ctl1;
   logic [1:0] htrans_i;
   logic [2:0] hsize_i, prescaler_o;
   logic [7:0] pfd_pump_o, pll_ctl2_o;
   logic [13:0] ref_div_o;
   logic [5:0] swallow_o;
   logic [12:0] feedback_o;
   logic rst_ref_cnt_o, rst_ab_cnt_o, rst_all_cnt_o, fb_bypass_o, lsb_first_o, sdo_active_o;
   logic lsb_mode, sdo_mode;
   int failures, num_checks, cycles;

   scp_link_if link ();
   scp_host i_scp_host (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
      .hrdata_o(hrdata_o), .hresp_o(hresp_o), .link(link.host));
   scp_dev i_scp_dev (.link(link.dev), .arst_n_i(arst_n_i), .pfd_pump_o(pfd_pump_o),
      .ref_div_o(ref_div_o), .swallow_o(swallow_o), .feedback_o(feedback_o),
      .rst_ref_cnt_o(rst_ref_cnt_o), .rst_ab_cnt_o(rst_ab_cnt_o), .rst_all_cnt_o(rst_all_cnt_o),
      .fb_bypass_o(fb_bypass_o), .prescaler_o(prescaler_o), .pll_ctl2_o(pll_ctl2_o),
      .lsb_first_o(lsb_first_o), .sdo_active_o(sdo_active_o));
   scp_link_sva i_scp_link_sva (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cs_n(link.cs_n),
      .sclk(link.sclk), .host_sdio(link.host_sdio), .host_sdio_oe(link.host_sdio_oe),
      .dev_sdio_oe(link.dev_sdio_oe), .dev_sdo(link.dev_sdo));

   // Control bits 6:0 of the first PLL control register as one word
   assign ctl1 = {25'h0, rst_ref_cnt_o, rst_ab_cnt_o, rst_all_cnt_o, fb_bypass_o, prescaler_o};

   // System clock, 100 ns period
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // Hang guard, well above the few thousand cycles the frames need
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         tally_and_finish();
      end
   end

   // One single-word bus transfer; read data taken at the end of the data phase
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      hsize_i <= 3'h2;
      do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= wd;
      do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask

   // Load instruction and data, start, wait for done, fetch received bytes
   task automatic frame(input logic rw, input logic [1:0] len, input logic [9:0] a,
                        input logic [2:0] n, input logic [31:0] tx);
      logic [31:0] st;
      xfer(1'b1, scp_pkg::H_INSTR, {16'h0, rw, len, 3'h0, a}, st);
      xfer(1'b1, scp_pkg::H_TXDATA, tx, st);
      xfer(1'b1, scp_pkg::H_CTRL, {22'h0, sdo_mode, lsb_mode, 5'h0, n}, st);
      repeat (2) @(posedge sys_clk_i);
      st = 32'h1;
      while (st[scp_pkg::STAT_BUSY_BIT] !== 1'b0 || st[scp_pkg::STAT_DONE_BIT] !== 1'b1) begin
         xfer(1'b0, scp_pkg::H_STATUS, 32'h0, st);
      end
      xfer(1'b0, scp_pkg::H_RXDATA, 32'h0, rx);
   endtask

   task automatic wr1(input logic [9:0] a, input logic [7:0] d);
      frame(1'b0, 2'h0, a, 3'h1, {24'h0, d});
   endtask

   task automatic rd1(input logic [9:0] a);
      frame(1'b1, 2'h0, a, 3'h1, 32'h0);
   endtask

   initial begin
      arst_n_i <= 1'b0;
      hsel_i = 1'b0;
      haddr_i = 32'h0;
      htrans_i = 2'h0;
      hwrite_i = 1'b0;
      hsize_i = 3'h2;
      hwdata_i = 32'h0;
      lsb_mode = 1'b0;
      sdo_mode = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      // Reset values, active side and buffer side
      check("ref divider", {18'h0, ref_div_o}, 32'h1);
      check("control one", ctl1, 32'h6);
      check("pump control", {24'h0, pfd_pump_o}, {24'h0, scp_pkg::REG_RST[scp_pkg::IDX_PFD]});
      for (int i = 0; i < scp_pkg::NREG; i++) begin
         rd1(scp_pkg::REG_ADDR[i]);
         check("reset value", {24'h0, rx[7:0]}, {24'h0, scp_pkg::REG_RST[i]});
      end
      // Two bytes counting down, held until the update bit
      frame(1'b0, 2'h1, 10'h012, 3'h2, 32'h0000552a);
      frame(1'b1, 2'h1, 10'h012, 3'h2, 32'h0);
      check("msb pair", {16'h0, rx[15:0]}, 32'h552a);
      check("not yet active", {18'h0, ref_div_o}, 32'h1);
      wr1(scp_pkg::ADDR_UPDATE, 8'h01);
      check("ref divider", {18'h0, ref_div_o}, 32'h2a55);
      rd1(scp_pkg::ADDR_UPDATE);
      check("update self clear", {24'h0, rx[7:0]}, 32'h0);
      // Three bytes into the control and feedback registers
      frame(1'b0, 2'h2, 10'h016, 3'h3, 32'h00a31f5d);
      wr1(scp_pkg::ADDR_UPDATE, 8'h01);
      check("control one", ctl1, 32'h5d);
      check("feedback", {19'h0, feedback_o}, 32'h1fa3);
      // Readback source: active copy read, then buffer copy selected again and updated
      wr1(10'h004, 8'h01);
      wr1(scp_pkg::ADDR_UPDATE, 8'h01);
      wr1(10'h013, 8'h22);
      rd1(10'h013);
      check("active read", {24'h0, rx[7:0]}, 32'h0);
      wr1(10'h004, 8'h00);
      wr1(scp_pkg::ADDR_UPDATE, 8'h01);
      check("swallow", {26'h0, swallow_o}, 32'h22);
      // Downward stream wraps from the bottom to the update address and stops
      wr1(10'h017, 8'h3c);
      frame(1'b0, 2'h3, 10'h001, 3'h4, 32'hee01185a);
      check("stream update", {24'h0, pll_ctl2_o}, 32'h3c);
      frame(1'b1, 2'h3, 10'h001, 3'h4, 32'h0);
      check("msb stream read", rx, 32'hff001800);
      // Low bit first: pair counting up, stream up to the top
      wr1(10'h000, 8'h5a);
      check("lsb mode", {31'h0, lsb_first_o}, 32'h1);
      lsb_mode = 1'b1;
      frame(1'b0, 2'h1, 10'h013, 3'h2, 32'h00004407);
      frame(1'b0, 2'h3, 10'h230, 3'h4, 32'h77019999);
      check("swallow", {26'h0, swallow_o}, 32'h07);
      check("feedback", {19'h0, feedback_o}, 32'h1f44);
      // Separate output line, read back low bit first
      wr1(10'h000, 8'hdb);
      check("sdo mode", {31'h0, sdo_active_o}, 32'h1);
      sdo_mode = 1'b1;
      frame(1'b1, 2'h1, 10'h013, 3'h2, 32'h0);
      check("lsb pair", {16'h0, rx[15:0]}, 32'h4407);
      wr1(10'h000, 8'h18);
      lsb_mode = 1'b0;
      sdo_mode = 1'b0;
      rd1(10'h016);
      check("back to msb", {24'h0, rx[7:0]}, 32'h5d);
      tally_and_finish();
   end
endmodule
`default_nettype wire
